//--- rtl/ccpu_unit.sv
// ccpu_unit: one capture/compare/pwm channel with an axi4-lite register slave
// assumes timers one and two, the converter and the pin pad live outside;
// all inputs except the asynchronous reset arst_n are synchronous to clock
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module ccpu_unit #(
	parameter int ADDR_WIDTH = 10
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire ccpu_pkg::ccpu_timers_t timers,
	input wire logic adc_enabled,
	output ccpu_pkg::ccpu_trig_t trig,
	output logic timer_two_clear,
	input wire logic channel_pin_i,
	output logic channel_pin_o,
	output logic channel_pin_oe_n,
	output logic channel_irq
);
	import ccpu_pkg::*;

	// ----------------------------------------------------------------
	// decoding helpers
	// ----------------------------------------------------------------
	// mode groups
	function automatic logic is_capture(input logic [3:0] m);
		return m[3:2] == 2'b01;
	endfunction

	function automatic logic is_compare(input logic [3:0] m);
		return m[3:2] == 2'b10;
	endfunction

	function automatic logic is_pwm(input logic [3:0] m);
		return m[3:2] == 2'b11;
	endfunction

	// mapped register indices
	function automatic logic known_index(input logic [7:0] idx);
		return idx == IDX_PIN_DATA || idx == IDX_FLAG_BANK || idx == IDX_VALUE_LOW
			|| idx == IDX_VALUE_HIGH || idx == IDX_CONTROL
			|| idx == IDX_PIN_DIRECTION || idx == IDX_ENABLE_BANK;
	endfunction

	// capture prescaler: high on the rise that completes a group, every group
	function automatic logic cap_due(input logic [3:0] m, input logic [3:0] count);
		logic due;
		unique case (m)
			MODE_CAP_RISE4: due = count[1:0] == CAP_LAST_OF_4[1:0];
			MODE_CAP_RISE16: due = count == CAP_LAST_OF_16;
			default: due = 1'b1;
		endcase
		return due;
	endfunction

	// one-bit register fields sit at the channel bit, the rest read 0
	function automatic logic [7:0] channel_byte(input logic b);
		logic [7:0] r;
		r = 8'h00;
		r[CHANNEL_BIT] = b;
		return r;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// registered state and its next value
	ccpu_state_t s;
	ccpu_state_t next_s;
	// decoded views and event strobes
	logic [3:0] mode;
	logic [7:0] ridx;
	logic [7:0] read_byte;
	logic do_write;
	logic set_flag;
	logic fall_edge;
	logic rise_edge;
	logic cap_event;
	logic match_now;
	logic match_edge;
	logic period_end;
	logic [9:0] duty_new;
	logic [9:0] pwm_count;
	logic duty_end;
	logic mode_change;

	assign mode = s.control[3:0];
	assign ridx = s_axi_araddr[9:2];
	assign do_write = s.aw_got && s.w_got && !s.bvalid;
	assign mode_change = do_write && s.wstrb0 && s.waddr == IDX_CONTROL && s.wdata[3:0] != mode;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	// handshakes on the bus
	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready = !s.w_got && !s.bvalid;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rdata = s.rdata;

	// ----------------------------------------------------------------
	// pin, trigger and interrupt outputs
	// ----------------------------------------------------------------
	// outputs from the state
	assign trig = s.trig;
	assign channel_pin_o = s.pin_out;
	assign channel_pin_oe_n = s.direction;
	assign channel_irq = s.irq;

	// ----------------------------------------------------------------
	// event detection
	// ----------------------------------------------------------------
	// pin edges for capture
	assign fall_edge = s.pin_q && !channel_pin_i;
	assign rise_edge = !s.pin_q && channel_pin_i;

	// compare equality, acted on once per match
	assign match_now = is_compare(mode) && {s.value_high, s.value_low} == timers.timer_one;
	assign match_edge = match_now && !s.match_q;

	// pwm period end on the timer two increment
	assign period_end = is_pwm(mode) && timers.timer_two_tick
		&& timers.timer_two == timers.timer_two_period;
	assign timer_two_clear = period_end;
	assign duty_new = {s.value_low, s.control[DUTY_LSB+1:DUTY_LSB]};

	// time base one sub-step ahead, since the latch drops one edge after the match
	assign pwm_count = {timers.timer_two, timers.timer_two_sub} + 10'd1;
	assign duty_end = is_pwm(mode) && {s.value_high, s.duty_latch} == pwm_count;

	// ----------------------------------------------------------------
	// capture condition
	// ----------------------------------------------------------------
	// capture condition per mode
	always_comb begin
		cap_event = 1'b0;
		unique case (mode)
			MODE_CAP_FALL: cap_event = fall_edge;
			MODE_CAP_RISE: cap_event = rise_edge;
			MODE_CAP_RISE4: cap_event = rise_edge && cap_due(mode, s.cap_count);
			MODE_CAP_RISE16: cap_event = rise_edge && cap_due(mode, s.cap_count);
			default: cap_event = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// read view
	// ----------------------------------------------------------------
	// register read view
	always_comb begin
		read_byte = 8'h00;
		unique case (ridx)
			IDX_PIN_DATA: read_byte = channel_byte(channel_pin_i);
			IDX_FLAG_BANK: read_byte = channel_byte(s.flag);
			IDX_VALUE_LOW: read_byte = s.value_low;
			IDX_VALUE_HIGH: read_byte = s.value_high;
			IDX_CONTROL: read_byte = {2'b00, s.control};
			IDX_PIN_DIRECTION: read_byte = channel_byte(s.direction);
			IDX_ENABLE_BANK: read_byte = channel_byte(s.irq_en);
			default: read_byte = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		set_flag = 1'b0;
		next_s.trig = '0;
		next_s.pin_q = channel_pin_i;
		next_s.match_q = match_now;

		// ------------------------------------------------------------
		// capture
		// ------------------------------------------------------------
		// capture: prescale count and snapshot of timer one
		if (is_capture(mode)) begin
			if (rise_edge) begin
				next_s.cap_count = s.cap_count + 4'h1;
			end
			if (cap_event) begin
				next_s.value_high = timers.timer_one[15:8];
				next_s.value_low = timers.timer_one[7:0];
				set_flag = 1'b1;
			end
		end

		// ------------------------------------------------------------
		// compare
		// ------------------------------------------------------------
		// compare actions on a fresh match
		if (match_edge) begin
			set_flag = 1'b1;
			unique case (mode)
				MODE_CMP_SET: next_s.out_latch = 1'b1;
				MODE_CMP_CLEAR: next_s.out_latch = 1'b0;
				MODE_CMP_SOFT: next_s.out_latch = s.out_latch;
				default: begin
					next_s.trig.timer_one_clear = 1'b1;
					next_s.trig.adc_start = adc_enabled;
				end
			endcase
		end

		// ------------------------------------------------------------
		// pwm
		// ------------------------------------------------------------
		// pwm: duty end clears, period end reloads and sets unless the new duty is zero
		if (is_pwm(mode)) begin
			if (duty_end) begin
				next_s.out_latch = 1'b0;
			end
			if (period_end) begin
				next_s.out_latch = duty_new != 10'h000;
				next_s.value_high = s.value_low;
				next_s.duty_latch = s.control[DUTY_LSB+1:DUTY_LSB];
			end
		end

		// ------------------------------------------------------------
		// channel off
		// ------------------------------------------------------------
		// channel off: output latch, prescale count, duty latch and match history back to rest
		if (mode == MODE_OFF) begin
			next_s.out_latch = 1'b0;
			next_s.cap_count = 4'h0;
			next_s.duty_latch = 2'b00;
			next_s.match_q = 1'b0;
		end

		// ------------------------------------------------------------
		// write channel
		// ------------------------------------------------------------
		// write address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.aw_got = 1'b1;
			next_s.waddr = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata[7:0];
			next_s.wstrb0 = s_axi_wstrb[0];
		end

		// ------------------------------------------------------------
		// register write
		// ------------------------------------------------------------
		// register write once both halves are held
		if (do_write) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = known_index(s.waddr) ? RESP_OKAY : RESP_SLVERR;
			if (s.wstrb0) begin
				unique case (s.waddr)
					IDX_PIN_DATA: next_s.pin_data = s.wdata[CHANNEL_BIT];
					IDX_FLAG_BANK: begin
						if (!s.wdata[CHANNEL_BIT]) begin
							next_s.flag = 1'b0;
						end
					end
					IDX_VALUE_LOW: next_s.value_low = s.wdata;
					IDX_VALUE_HIGH: begin
						if (!is_pwm(mode)) begin
							next_s.value_high = s.wdata;
						end
					end
					IDX_CONTROL: begin
						next_s.control = s.wdata[5:0];
						if (mode_change) begin
							next_s.cap_count = 4'h0;
							next_s.out_latch = 1'b0;
						end
					end
					IDX_PIN_DIRECTION: next_s.direction = s.wdata[CHANNEL_BIT];
					IDX_ENABLE_BANK: next_s.irq_en = s.wdata[CHANNEL_BIT];
					default: next_s.bresp = RESP_SLVERR;
				endcase
			end
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end

		// ------------------------------------------------------------
		// read channel
		// ------------------------------------------------------------
		// read answer one cycle after the address
		if (s_axi_arvalid && s_axi_arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = {24'h000000, read_byte};
			next_s.rresp = known_index(ridx) ? RESP_OKAY : RESP_SLVERR;
		end
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end

		// ------------------------------------------------------------
		// flag
		// ------------------------------------------------------------
		// hardware set wins over software clear
		if (set_flag) begin
			next_s.flag = 1'b1;
		end

		// ------------------------------------------------------------
		// pin and interrupt
		// ------------------------------------------------------------
		// pin source: compare/pwm latch or plain data latch
		if (is_compare(next_s.control[3:0]) || is_pwm(next_s.control[3:0])) begin
			next_s.pin_out = next_s.out_latch;
		end else begin
			next_s.pin_out = next_s.pin_data;
		end
		next_s.irq = next_s.flag && next_s.irq_en;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.control <= CONTROL_RESET;
			s.direction <= DIRECTION_RESET;
		end else begin
			s <= next_s;
		end
	end

endmodule

`default_nettype wire

//--- rtl/ccpu_pkg.sv
// ccpu_pkg: shared constants and carrier types of the capture/compare/pwm unit
// assumes a 32-bit axi4-lite register bus, word index = byte address / 4
`default_nettype none
package ccpu_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_PIN_DATA = 8'h07;
	localparam logic [7:0] IDX_FLAG_BANK = 8'h0c;
	localparam logic [7:0] IDX_VALUE_LOW = 8'h15;
	localparam logic [7:0] IDX_VALUE_HIGH = 8'h16;
	localparam logic [7:0] IDX_CONTROL = 8'h17;
	localparam logic [7:0] IDX_PIN_DIRECTION = 8'h87;
	localparam logic [7:0] IDX_ENABLE_BANK = 8'h8c;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CHANNEL_BIT = 2; // flag, enable, pin data and direction bit
	localparam int DUTY_LSB = 4; // duty_low_bits in channel_control
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET = 4'h8;
	localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
	localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
	localparam logic [3:0] CAP_LAST_OF_4 = 4'h3;
	localparam logic [3:0] CAP_LAST_OF_16 = 4'hf;
	localparam logic [5:0] CONTROL_RESET = 6'h00;
	localparam logic DIRECTION_RESET = 1'b1; // pin starts as input
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	// timer state seen by the unit
	typedef struct packed {
		logic [15:0] timer_one;
		logic [7:0] timer_two;
		logic [7:0] timer_two_period;
		logic timer_two_tick; // timer two increments this cycle
		logic [1:0] timer_two_sub; // quarter-cycle or prescaler count
	} ccpu_timers_t;

	// special event trigger pulses
	typedef struct packed {
		logic timer_one_clear;
		logic adc_start;
	} ccpu_trig_t;

	// whole state of the unit
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] waddr;
		logic [7:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [5:0] control;
		logic [7:0] value_low;
		logic [7:0] value_high;
		logic [1:0] duty_latch;
		logic flag;
		logic irq_en;
		logic pin_data;
		logic direction;
		logic out_latch;
		logic pin_q;
		logic [3:0] cap_count;
		logic match_q;
		logic pin_out;
		logic irq;
		ccpu_trig_t trig;
	} ccpu_state_t;

endpackage
`default_nettype wire

//--- verification/ccpu_timer_model.sv
// ccpu_timer_model: timers one and two as seen by the unit
// assumes one clock, timer two steps every fourth cycle, prescale one
`timescale 1ns/1ns
`default_nettype none
module ccpu_timer_model (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic t1_run,
	input wire logic [7:0] period,
	input wire ccpu_pkg::ccpu_trig_t trig,
	input wire logic timer_two_clear,
	output ccpu_pkg::ccpu_timers_t timers
);
	import ccpu_pkg::*;
	// counts; the special clear never raises an overflow flag
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			timers <= '0;
		end else begin
			timers.timer_two_period <= period;
			timers.timer_two_sub <= timers.timer_two_sub + 2'h1;
			timers.timer_two_tick <= timers.timer_two_sub == 2'h2;
			if (trig.timer_one_clear) timers.timer_one <= 16'h0000;
			else if (t1_run) timers.timer_one <= timers.timer_one + 16'h0001;
			if (timer_two_clear) timers.timer_two <= 8'h00;
			else if (timers.timer_two_tick) timers.timer_two <= timers.timer_two + 8'h01;
		end
	end
endmodule
`default_nettype wire

//--- verification/ccpu_unit_properties.sv
// ccpu_unit_properties: port-level checks of the unit
// assumes binding to ccpu_unit
`timescale 1ns/1ns
`default_nettype none
module ccpu_unit_properties (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire ccpu_pkg::ccpu_timers_t timers,
	input wire logic adc_enabled,
	input wire ccpu_pkg::ccpu_trig_t trig,
	input wire logic timer_two_clear,
	input wire logic channel_pin_oe_n,
	input wire logic channel_irq
);
	import ccpu_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	AST_TRIG_PULSE: assert property (trig.timer_one_clear |=> !trig.timer_one_clear)
		else $error("timer clear pulse too long");
	AST_ADC_GATE: assert property (trig.adc_start |-> trig.timer_one_clear && $past(adc_enabled))
		else $error("conversion start without special event");
	AST_T2_CLEAR: assert property (timer_two_clear |->
		timers.timer_two_tick && timers.timer_two == timers.timer_two_period)
		else $error("timer two clear off period match");
	AST_OE_WRITE: assert property ($changed(channel_pin_oe_n) |-> $rose(s_axi_bvalid))
		else $error("pin direction moved without write");
	AST_IRQ_FALL: assert property ($fell(channel_irq) |-> $rose(s_axi_bvalid))
		else $error("irq dropped without write");
	AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered next cycle");
	AST_WRITE_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
endmodule
bind ccpu_unit ccpu_unit_properties chk_u (.clock(clock), .arst_n(arst_n),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rdata(s_axi_rdata), .timers(timers), .adc_enabled(adc_enabled), .trig(trig),
	.timer_two_clear(timer_two_clear), .channel_pin_oe_n(channel_pin_oe_n),
	.channel_irq(channel_irq));
`default_nettype wire

//--- verification/capture_compare_pwm_unit_tb_top.sv
// capture_compare_pwm_unit_tb_top: self-checking bench of the unit
// assumes the unit, timer model and checker are compiled before it
`timescale 1ns/1ns
`default_nettype none
module capture_compare_pwm_unit_tb_top;
	import ccpu_pkg::*;
	logic clock = 0, arst_n = 0, awvalid = 0, wvalid = 0, arvalid = 0, t1_run = 1, pin_drv = 0;
	logic [9:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [7:0] period = 8'h08;
	logic adc_en = 1;
	logic awready, wready, bvalid, arready, rvalid, t2_clear, pin_o, oe_n, irq;
	logic [1:0] bresp, rresp;
	logic [15:0] lfsr = 16'h0036;
	ccpu_timers_t timers;
	ccpu_trig_t trig;
	int error_cnt = 0, n_compared = 0, ntrig = 0, nadc = 0;
	wire logic pin_i = oe_n ? pin_drv : pin_o;
	ccpu_unit dut_u (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .timers(timers),
		.adc_enabled(adc_en), .trig(trig), .timer_two_clear(t2_clear), .channel_pin_i(pin_i),
		.channel_pin_o(pin_o), .channel_pin_oe_n(oe_n), .channel_irq(irq));
	ccpu_timer_model tm_u (.clock(clock), .arst_n(arst_n), .t1_run(t1_run), .period(period),
		.trig(trig), .timer_two_clear(t2_clear), .timers(timers));
	// clock, trigger counting and watchdog
	initial forever #50 clock = ~clock;
	always @(negedge clock) begin
		ntrig += trig.timer_one_clear;
		nadc += trig.adc_start;
	end
	initial begin
		#4000000;
		error_cnt++;
		report_and_stop();
	end
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic a, w, b;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge clock);
			{a, w, b} = {awready, wready, bvalid};
			if (b) chk(bresp, RESP_OKAY);
			@(posedge clock);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (!b);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
		logic a, v;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		do begin
			@(negedge clock);
			{a, v} = {arready, rvalid};
			if (v) chk(rdata, exp);
			if (v) chk(rresp, er);
			@(posedge clock);
			if (a) arvalid <= 1'b0;
		end while (!v);
	endtask
	task automatic pin(input logic x);
		pin_drv <= x;
		repeat (3) @(posedge clock);
	endtask
	task automatic pwm_run(input logic [9:0] d, input logic [1:0] ms, output int hi, output int len);
		wr(IDX_VALUE_LOW, d[9:2]);
		wr(IDX_CONTROL, {2'b00, d[1:0], 2'b11, ms});
		repeat (2) do @(negedge clock); while (t2_clear !== 1'b1);
		hi = 0;
		len = 0;
		do begin
			@(negedge clock);
			hi += pin_o === 1'b1;
			len++;
		end while (t2_clear !== 1'b1);
		@(posedge clock);
	endtask
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		logic [15:0] v;
		logic [9:0] d1;
		int n, hi, h1, len;
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		rd(IDX_CONTROL, 0, RESP_OKAY);
		rd(IDX_PIN_DIRECTION, 32'h4, RESP_OKAY);
		rd(8'h40, 0, RESP_SLVERR);
		wr(IDX_ENABLE_BANK, 8'h04);
		// capture with timer one frozen at a random count
		v = rnd();
		repeat (v[10:0]) @(posedge clock);
		t1_run <= 1'b0;
		repeat (2) @(posedge clock);
		v = timers.timer_one;
		for (int m = 4; m < 8; m++) begin
			n = m == 7 ? 16 : m == 6 ? 4 : 1;
			wr(IDX_CONTROL, m[7:0]);
			wr(IDX_VALUE_LOW, 8'h00);
			wr(IDX_VALUE_HIGH, 8'h00);
			for (int k = 1; k <= n; k++) begin
				pin(1'b1);
				rd(IDX_VALUE_LOW, k == n && m != 4 ? v[7:0] : 0, RESP_OKAY);
				pin(1'b0);
				rd(IDX_VALUE_LOW, k == n ? v[7:0] : 0, RESP_OKAY);
			end
			rd(IDX_VALUE_HIGH, {24'h0, v[15:8]}, RESP_OKAY);
		end
		// captures left the flag up; clear it before watching compares
		chk(irq, 1);
		rd(IDX_FLAG_BANK, 32'h4, RESP_OKAY);
		wr(IDX_FLAG_BANK, 8'h00);
		chk(irq, 0);
		// compare modes against a running timer one, last pass with converter off
		t1_run <= 1'b1;
		wr(IDX_PIN_DIRECTION, 8'h00);
		chk(oe_n, 0);
		for (int m = 8; m < 13; m++) begin
			adc_en <= m != 12;
			wr(IDX_CONTROL, m == 12 ? {4'h0, MODE_CMP_SPECIAL} : m[7:0]);
			v = rnd();
			v = timers.timer_one + 16'd80 + v[4:0];
			wr(IDX_VALUE_LOW, v[7:0]);
			wr(IDX_VALUE_HIGH, v[15:8]);
			ntrig = 0;
			nadc = 0;
			do @(negedge clock); while (irq !== 1'b1);
			@(negedge clock);
			chk(pin_o, m == 8);
			chk(ntrig, m > 10);
			chk(nadc, m == 11);
			@(posedge clock);
			wr(IDX_FLAG_BANK, 8'h00);
			wr(IDX_CONTROL, 8'h00);
			chk(irq, 0);
			chk(pin_o, 0);
		end
		// pwm on timer two
		v = rnd();
		period <= {2'b00, v[5:0]} + 8'h08;
		d1 = {5'h00, v[10:6]} + 10'd1;
		pwm_run(10'h000, 2'd0, hi, len);
		chk(hi, 0);
		chk(len, (period + 1) * 4);
		pwm_run(d1, 2'd1, h1, len);
		chk(h1, d1);
		pwm_run(d1 + 10'd3, 2'd2, hi, len);
		chk(hi - h1, 3);
		pwm_run(10'h3ff, 2'd3, hi, len);
		chk(hi, len);
		rd(IDX_VALUE_HIGH, 32'hff, RESP_OKAY);
		wr(IDX_VALUE_HIGH, 8'h12);
		rd(IDX_VALUE_HIGH, 32'hff, RESP_OKAY);
		report_and_stop();
	end
endmodule
`default_nettype wire
